// *** include/ctd_consts.vh ***
`ifndef CTD_CONSTS_VH
`define CTD_CONSTS_VH

`define CTD_TAG_W        8
`define CTD_WIDTH_W      4
`define CTD_GROUP_W_DEF  0
`define CTD_TAG_RESET    8'h00
`define CTD_ZERO_TAG     8'h00
`define CTD_ALL_ONES     8'hff
`define CTD_PRIMARY      1'b0
`define CTD_SETTLE_CYC   2'h2

`endif

// *** design/ctd_field_split.v ***
`timescale 1ns/1ps
`include "ctd_consts.vh"

module ctd_field_split (
	input  wire [`CTD_TAG_W-1:0]   tag_in,     // full identifier
	input  wire [`CTD_WIDTH_W-1:0] shift_in,   // low bit of field
	input  wire [`CTD_WIDTH_W-1:0] width_in,   // field width, may be zero
	output wire [`CTD_TAG_W-1:0]   field_out   // field right-aligned
);

	wire [`CTD_TAG_W-1:0] shifted;
	wire [`CTD_TAG_W-1:0] mask;

	assign shifted   = tag_in >> shift_in;
	// Zero width gives an empty mask, so the field reads zero
	assign mask      = ~(`CTD_ALL_ONES << width_in);
	assign field_out = shifted & mask;

endmodule

// *** design/ctd_topology_decoder.v ***
// Contract
// - Each logical processor gets an 8-bit identifier split into hierarchy sub-fields.
// - Up to four sub-fields: group, socket, execution unit, thread.
// - Group field separates clusters; zero in non-clustered systems.
// - Socket field differs for each package within one cluster.
// - Execution unit field separates cores; zero width when one core.
// - Thread field separates threads in a core; non-zero width if several.
// - Thread and core fields sit adjacent and contiguous at the low end.
// - Field widths come from configuration and are readable at runtime; group width is not output.
// - After reset each logical processor gets a system-unique identifier.
// - Identifiers need not be contiguous; some values may stay unused.
// - One core, two threads: bit 0 thread, upper bits package, core zero.
// - Two cores, two threads: bit 0 thread, bit 1 core, next package.
// - Parts reporting no core count decode core index as zero.
// - Thread 0 is primary, thread 1 secondary within a package.
`timescale 1ns/1ps
`include "ctd_consts.vh"

module ctd_topology_decoder #(
	parameter TAG_W = `CTD_TAG_W
) (
	input  wire                    clk_in,             // 40 MHz clock
	input  wire                    resetn_in,          // async reset, active low
	input  wire [`CTD_WIDTH_W-1:0] thread_bits_in,     // thread field width strap
	input  wire [`CTD_WIDTH_W-1:0] core_bits_in,       // core field width strap
	input  wire [`CTD_WIDTH_W-1:0] group_bits_in,      // group field width strap
	input  wire                    core_count_ok_in,   // part reports core count
	input  wire [TAG_W-1:0]        group_strap_in,     // cluster number strap
	input  wire [TAG_W-1:0]        socket_strap_in,    // package number strap
	input  wire [TAG_W-1:0]        unit_strap_in,      // core number strap
	input  wire [TAG_W-1:0]        thread_strap_in,    // thread number strap
	output reg  [TAG_W-1:0]        initial_cpu_tag_out, // assembled identifier
	output reg  [TAG_W-1:0]        group_index_out,    // cluster index
	output reg  [TAG_W-1:0]        socket_index_out,   // package index
	output reg  [TAG_W-1:0]        exec_unit_index_out, // core index
	output reg  [TAG_W-1:0]        thread_index_out,   // thread index
	output reg  [`CTD_WIDTH_W-1:0] thread_width_out,   // thread field width
	output reg  [`CTD_WIDTH_W-1:0] core_width_out,     // core field width
	output reg  [`CTD_WIDTH_W-1:0] socket_shift_out,   // package field position
	output reg                     primary_out,        // set when thread index bit 0 is clear
	output reg                     tag_valid_out       // identifier settled
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Straps are asynchronous pins; stage 1 feeds stage 2 only.
	localparam SYNC_W = 3 * `CTD_WIDTH_W + 1 + 4 * TAG_W;

	reg [SYNC_W-1:0] sync1_r;
	reg [SYNC_W-1:0] sync2_r;

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync1_r <= {SYNC_W{1'b0}};
			sync2_r <= {SYNC_W{1'b0}};
		end else begin
			sync1_r <= {thread_bits_in, core_bits_in, group_bits_in, core_count_ok_in,
				group_strap_in, socket_strap_in, unit_strap_in, thread_strap_in};
			sync2_r <= sync1_r;
		end
	end

	wire [`CTD_WIDTH_W-1:0] s_tbits;
	wire [`CTD_WIDTH_W-1:0] s_cbits;
	wire [`CTD_WIDTH_W-1:0] s_gbits;
	wire                    s_cok;
	wire [TAG_W-1:0]        s_group;
	wire [TAG_W-1:0]        s_socket;
	wire [TAG_W-1:0]        s_unit;
	wire [TAG_W-1:0]        s_thread;

	assign {s_tbits, s_cbits, s_gbits, s_cok, s_group, s_socket, s_unit, s_thread} = sync2_r;

	// ----------------------------------------------------------------
	// Capture after reset release
	// ----------------------------------------------------------------
	// Straps are latched once after the synchroniser fills, then frozen,
	// so the identifier stays fixed until the next reset.
	localparam ST_SETTLE = 2'b00;
	localparam ST_LATCH  = 2'b01;
	localparam ST_HOLD   = 2'b10;

	reg [1:0]               state_r;
	reg [1:0]               state_nxt;
	reg [1:0]               cnt_r;
	reg [`CTD_WIDTH_W-1:0]  tbits_r;
	reg [`CTD_WIDTH_W-1:0]  cbits_r;
	reg [`CTD_WIDTH_W-1:0]  gbits_r;
	reg                     cok_r;
	reg [TAG_W-1:0]         group_r;
	reg [TAG_W-1:0]         socket_r;
	reg [TAG_W-1:0]         unit_r;
	reg [TAG_W-1:0]         thread_r;

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_SETTLE: begin
				if (cnt_r == `CTD_SETTLE_CYC)
					state_nxt = ST_LATCH;
			end
			ST_LATCH: state_nxt = ST_HOLD;
			ST_HOLD:  state_nxt = ST_HOLD;
			default:  state_nxt = ST_SETTLE;
		endcase
	end

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r  <= ST_SETTLE;
			cnt_r    <= 2'b00;
			tbits_r  <= {`CTD_WIDTH_W{1'b0}};
			cbits_r  <= {`CTD_WIDTH_W{1'b0}};
			gbits_r  <= {`CTD_WIDTH_W{1'b0}};
			cok_r    <= 1'b0;
			group_r  <= {TAG_W{1'b0}};
			socket_r <= {TAG_W{1'b0}};
			unit_r   <= {TAG_W{1'b0}};
			thread_r <= {TAG_W{1'b0}};
		end else begin
			state_r <= state_nxt;
			if (state_r == ST_SETTLE)
				cnt_r <= cnt_r + 2'b01;
			if (state_r == ST_LATCH) begin
				tbits_r  <= s_tbits;
				cbits_r  <= s_cbits;
				gbits_r  <= s_gbits;
				cok_r    <= s_cok;
				group_r  <= s_group;
				socket_r <= s_socket;
				unit_r   <= s_unit;
				thread_r <= s_thread;
			end
		end
	end

	// ----------------------------------------------------------------
	// Identifier assembly
	// ----------------------------------------------------------------
	// Field positions: thread at bit 0, core directly above, then socket,
	// then group. Unused codes between sockets are allowed to stay empty.
	wire [`CTD_WIDTH_W-1:0] core_w_eff;
	wire [`CTD_WIDTH_W-1:0] sock_shift;
	wire [`CTD_WIDTH_W-1:0] sock_w;
	wire [`CTD_WIDTH_W-1:0] grp_shift;
	wire [TAG_W-1:0]        tag_build;

	assign core_w_eff = cok_r ? cbits_r : {`CTD_WIDTH_W{1'b0}};
	assign sock_shift = tbits_r + core_w_eff;
	assign grp_shift  = (gbits_r == {`CTD_WIDTH_W{1'b0}}) ?
		TAG_W[`CTD_WIDTH_W-1:0] : TAG_W[`CTD_WIDTH_W-1:0] - gbits_r;
	assign sock_w     = grp_shift - sock_shift;

	function [TAG_W-1:0] ctd_place;
		input [TAG_W-1:0]        val;
		input [`CTD_WIDTH_W-1:0] sh;
		input [`CTD_WIDTH_W-1:0] w;
		begin
			ctd_place = (val & ~(`CTD_ALL_ONES << w)) << sh;
		end
	endfunction

	assign tag_build = ctd_place(thread_r, {`CTD_WIDTH_W{1'b0}}, tbits_r)
		| ctd_place(unit_r, tbits_r, core_w_eff)
		| ctd_place(socket_r, sock_shift, sock_w)
		| ctd_place(group_r, grp_shift, gbits_r);

	// ----------------------------------------------------------------
	// Decode back into fields
	// ----------------------------------------------------------------
	wire [TAG_W-1:0] dec_thread;
	wire [TAG_W-1:0] dec_unit;
	wire [TAG_W-1:0] dec_socket;
	wire [TAG_W-1:0] dec_group;

	ctd_field_split u_thread (
		.tag_in    (tag_build),
		.shift_in  ({`CTD_WIDTH_W{1'b0}}),
		.width_in  (tbits_r),
		.field_out (dec_thread)
	);

	ctd_field_split u_unit (
		.tag_in    (tag_build),
		.shift_in  (tbits_r),
		.width_in  (core_w_eff),
		.field_out (dec_unit)
	);

	ctd_field_split u_socket (
		.tag_in    (tag_build),
		.shift_in  (sock_shift),
		.width_in  (sock_w),
		.field_out (dec_socket)
	);

	ctd_field_split u_group (
		.tag_in    (tag_build),
		.shift_in  (grp_shift),
		.width_in  (gbits_r),
		.field_out (dec_group)
	);

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			initial_cpu_tag_out <= `CTD_TAG_RESET;
			group_index_out     <= `CTD_ZERO_TAG;
			socket_index_out    <= `CTD_ZERO_TAG;
			exec_unit_index_out <= `CTD_ZERO_TAG;
			thread_index_out    <= `CTD_ZERO_TAG;
			thread_width_out    <= {`CTD_WIDTH_W{1'b0}};
			core_width_out      <= {`CTD_WIDTH_W{1'b0}};
			socket_shift_out    <= {`CTD_WIDTH_W{1'b0}};
			primary_out         <= 1'b0;
			tag_valid_out       <= 1'b0;
		end else if (state_r == ST_HOLD) begin
			initial_cpu_tag_out <= tag_build;
			group_index_out     <= dec_group;
			socket_index_out    <= dec_socket;
			exec_unit_index_out <= dec_unit;
			thread_index_out    <= dec_thread;
			thread_width_out    <= tbits_r;
			core_width_out      <= core_w_eff;
			socket_shift_out    <= sock_shift;
			primary_out         <= (dec_thread[0] == `CTD_PRIMARY);
			tag_valid_out       <= 1'b1;
		end
	end

endmodule

// *** bench/ctd_topology_decoder_monitor.sv ***
`timescale 1ns/1ps
`include "ctd_consts.vh"

module ctd_mon #(
	parameter TAG_W = 8
) (
	input wire                    clk_in,
	input wire                    resetn_in,
	input wire                    core_count_ok_in,
	input wire [`CTD_WIDTH_W-1:0] group_bits_in,
	input wire [TAG_W-1:0]        initial_cpu_tag_out,
	input wire [TAG_W-1:0]        group_index_out,
	input wire [TAG_W-1:0]        exec_unit_index_out,
	input wire [TAG_W-1:0]        thread_index_out,
	input wire [`CTD_WIDTH_W-1:0] thread_width_out,
	input wire [`CTD_WIDTH_W-1:0] core_width_out,
	input wire [`CTD_WIDTH_W-1:0] socket_shift_out,
	input wire                    primary_out,
	input wire                    tag_valid_out
);
	// ----
	// Straps may also change after reset release; tag must hold
	// ----
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	property p_hold; tag_valid_out |=> tag_valid_out && $stable(initial_cpu_tag_out); endproperty
	a_hold: assert property (p_hold) else $error("tag changed");
	property p_rise; $rose(resetn_in) |-> !tag_valid_out ##[3:6] tag_valid_out; endproperty
	a_rise: assert property (p_rise) else $error("valid late");
	property p_thr;
		tag_valid_out |-> thread_index_out ==
			(initial_cpu_tag_out & ~({TAG_W{1'b1}} << thread_width_out));
	endproperty
	a_thr: assert property (p_thr) else $error("thread field");
	property p_core;
		tag_valid_out |-> exec_unit_index_out ==
			((initial_cpu_tag_out >> thread_width_out) & ~({TAG_W{1'b1}} << core_width_out));
	endproperty
	a_core: assert property (p_core) else $error("core field");
	property p_adj;
		tag_valid_out |-> socket_shift_out == thread_width_out + core_width_out;
	endproperty
	a_adj: assert property (p_adj) else $error("fields apart");
	property p_pri; tag_valid_out |-> primary_out == !thread_index_out[0]; endproperty
	a_pri: assert property (p_pri) else $error("primary");
	property p_nocnt;
		tag_valid_out && !core_count_ok_in |-> core_width_out == 0 && exec_unit_index_out == 0;
	endproperty
	a_nocnt: assert property (p_nocnt) else $error("core not zero");
	property p_grp; tag_valid_out && group_bits_in == 0 |-> group_index_out == 0; endproperty
	a_grp: assert property (p_grp) else $error("group not zero");
endmodule

// *** bench/ctd_topology_decoder_tb.sv ***
`timescale 1ns/1ps

module ctd_topology_decoder_tb;
	logic       clk_in = 1'b0;
	logic       resetn_in = 1'b0;
	logic [3:0] tw, cw, gw;
	logic       cok;
	logic [7:0] gs, ss, us, ts;
	wire  [7:0] tag, gi, si, ui, ti;
	wire  [3:0] two, cwo, sso;
	wire        pri, vld;
	int         n_errors = 0;
	int         n_compared = 0;

	always #12.5 clk_in = ~clk_in;

	ctd_topology_decoder ctd_topology_decoder_inst (.clk_in(clk_in), .resetn_in(resetn_in),
		.thread_bits_in(tw), .core_bits_in(cw), .group_bits_in(gw), .core_count_ok_in(cok),
		.group_strap_in(gs), .socket_strap_in(ss), .unit_strap_in(us), .thread_strap_in(ts),
		.initial_cpu_tag_out(tag), .group_index_out(gi), .socket_index_out(si),
		.exec_unit_index_out(ui), .thread_index_out(ti), .thread_width_out(two),
		.core_width_out(cwo), .socket_shift_out(sso), .primary_out(pri), .tag_valid_out(vld));

	// ----
	// Shared tasks
	// ----
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic boot(input logic [3:0] t, c, g, input logic k, input logic [7:0] a, b, d, e);
		int i;
		@(negedge clk_in);
		resetn_in = 1'b0;
		{tw, cw, gw, cok, gs, ss, us, ts} = {t, c, g, k, a, b, d, e};
		repeat (2) @(negedge clk_in);
		chk(tag, 8'h00);
		resetn_in = 1'b1;
		for (i = 0; i < 20 && vld !== 1'b1; i++) @(negedge clk_in);
		chk({7'h00, vld}, 8'h01);
	endtask

	task automatic look(input logic [7:0] et, es, eu, eh);
		chk(tag, et);
		chk(si, es);
		chk(ui, eu);
		chk(ti, eh);
		chk({7'h00, pri}, {7'h00, ~eh[0]});
	endtask

	task automatic summarize;
		if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// ----
	// Scenarios
	// ----
	task automatic sc_one_core;
		for (int i = 0; i < 8; i++) begin
			boot(1, 0, 0, 1, 0, i >> 1, 0, i & 1);
			look(i, i >> 1, 0, i & 1);
		end
		chk({4'h0, cwo}, 8'h00);
		chk({4'h0, sso}, 8'h01);
	endtask

	task automatic sc_dual_core;
		for (int i = 0; i < 8; i++) begin
			boot(1, 1, 0, 1, 0, i >> 2, (i >> 1) & 1, i & 1);
			look(i, i >> 2, (i >> 1) & 1, i & 1);
		end
		chk({4'h0, sso}, 8'h02);
	endtask

	task automatic sc_no_count;
		boot(1, 1, 0, 0, 8'h05, 8'h03, 8'h01, 8'h00);
		look(8'h06, 8'h03, 8'h00, 8'h00);
		chk(gi, 8'h00);
		chk({4'h0, cwo}, 8'h00);
	endtask

	task automatic sc_group;
		boot(2, 1, 2, 1, 8'h02, 8'h01, 8'h01, 8'h03);
		look(8'h8f, 8'h01, 8'h01, 8'h03);
		chk(gi, 8'h02);
		chk({4'h0, two}, 8'h02);
		chk({4'h0, cwo}, 8'h01);
		chk({4'h0, sso}, 8'h03);
		ss = 8'h02;
		repeat (8) @(negedge clk_in);
		chk(tag, 8'h8f);
	endtask

	initial begin
		{tw, cw, gw, cok, gs, ss, us, ts} = '0;
		repeat (10) @(negedge clk_in);
		sc_one_core();
		sc_dual_core();
		sc_no_count();
		sc_group();
		summarize();
	end

	initial begin
		#100us;
		n_errors++;
		summarize();
	end
endmodule

bind ctd_topology_decoder ctd_mon #(.TAG_W(TAG_W)) ctd_mon_inst (.clk_in(clk_in),
	.resetn_in(resetn_in), .core_count_ok_in(core_count_ok_in), .group_bits_in(group_bits_in),
	.initial_cpu_tag_out(initial_cpu_tag_out), .group_index_out(group_index_out),
	.exec_unit_index_out(exec_unit_index_out), .thread_index_out(thread_index_out),
	.thread_width_out(thread_width_out), .core_width_out(core_width_out),
	.socket_shift_out(socket_shift_out), .primary_out(primary_out),
	.tag_valid_out(tag_valid_out));
